// *** hw/output_fault_status_map.vh ***
// constants for the output fault status reporter
`ifndef OUTPUT_FAULT_STATUS_MAP_VH
`define OUTPUT_FAULT_STATUS_MAP_VH
`define FAULT_STATUS_OFFSET  16'h9D73
`define FAULT_STATUS_RESET   8'h00
`define NUM_CHANNELS         16
`define NUM_GROUPS           8
`define GROUPS_SEVEN         4'h4
`define GROUPS_FULL          4'h8
`define CHAR_DOLLAR          8'h24
`define CHAR_BANG            8'h21
`define CHAR_ZERO            8'h30
`define CHAR_ONE             8'h31
`define CHAR_SEVEN           8'h37
`define CHAR_CR              8'h0D
`define REPLY_PREFIX_LEN     4'h3
`define STRAP_SETTLE         3'h4
`endif

// *** hw/output_fault_status_reporter.v ***
// output fault status reporter: register port and status command
`timescale 1ns/100ps
`include "output_fault_status_map.vh"
module output_fault_status_reporter (
	input  wire        clk_sys,
	input  wire        reset_n,
	input  wire        ce,
	input  wire [15:0] out_active,
	input  wire [15:0] open_load,
	input  wire [15:0] short_gnd,
	input  wire [15:0] over_current,
	input  wire        seven_channel,
	input  wire        reg_rd,
	input  wire        reg_wr,
	input  wire [15:0] reg_addr,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata,
	output reg         reg_ack,
	output reg         reg_err,
	input  wire        rx_valid,
	input  wire [7:0]  rx_data,
	output wire        rx_ready,
	output reg         tx_valid,
	output reg  [7:0]  tx_data,
	input  wire        tx_ready,
	output reg  [7:0]  group_status,
	output reg         variant_seven
);

localparam ST_IDLE  = 3'd0;
localparam ST_ADDR0 = 3'd1;
localparam ST_ADDR1 = 3'd2;
localparam ST_CMD   = 3'd3;
localparam ST_END   = 3'd4;
localparam ST_TX    = 3'd5;

// pin chain: 64 fault/activity bits plus the variant strap
localparam PIN_W = 65;
wire [64:0] pins = {seven_channel, over_current, short_gnd, open_load, out_active};
wire [64:0] filt;
reg  [2:0]  fill;
reg         strap_taken;

// stage one feeds stage two only, never the logic
// the third flop costs a cycle but rejects one-edge glitches
genvar pi;
generate
	for (pi = 0; pi < PIN_W; pi = pi + 1) begin : g_pin
		reg s1;
		reg s2;
		reg s3;
		reg held;
		always @(posedge clk_sys or negedge reset_n) begin
			if (!reset_n) begin
				s1 <= 1'b0;
				s2 <= 1'b0;
				s3 <= 1'b0;
				held <= 1'b0;
			end else if (ce) begin
				s1 <= pins[pi];
				s2 <= s1;
				s3 <= s2;
				// a level moves only once stages two and three agree
				if (s2 == s3) begin
					held <= s3;
				end
			end
		end
		assign filt[pi] = held;
	end
endgenerate

wire [15:0] f_act = filt[15:0];
wire [15:0] f_open = filt[31:16];
wire [15:0] f_short = filt[47:32];
wire [15:0] f_oc = filt[63:48];

wire [15:0] chan_fault;
genvar gi;
generate
	for (gi = 0; gi < `NUM_CHANNELS; gi = gi + 1) begin : g_chan
		assign chan_fault[gi] = (~f_act[gi] & f_open[gi]) |
		                        (~f_act[gi] & f_short[gi]) |
		                        (f_act[gi] & f_oc[gi]);
	end
endgenerate

function [7:0] group_fault;
	input [15:0] cf;
	input        seven;
	integer      k;
	begin
		group_fault = 8'h00;
		for (k = 0; k < `NUM_GROUPS; k = k + 1) begin
			group_fault[k] = cf[2*k] | cf[2*k+1];
		end
		if (seven) begin
			// channel 7 does not exist, groups 4..7 absent
			group_fault = {4'h0, cf[6], group_fault[2:0]};
		end
	end
endfunction

function [7:0] reply_char;
	input [3:0] idx;
	input [3:0] ngroups;
	input [7:0] snap;
	reg   [3:0] gsel;
	begin
		gsel = 4'h0;
		case (idx)
			4'h0: begin
				reply_char = `CHAR_BANG;
			end
			4'h1: begin
				reply_char = `CHAR_ZERO;
			end
			4'h2: begin
				reply_char = `CHAR_ONE;
			end
			default: begin
				if (idx < `REPLY_PREFIX_LEN + ngroups) begin
					gsel = ngroups - 4'h1 - (idx - `REPLY_PREFIX_LEN); // highest group first
					reply_char = snap[gsel[2:0]] ? `CHAR_ONE : `CHAR_ZERO;
				end else begin
					reply_char = `CHAR_CR;
				end
			end
		endcase
	end
endfunction

// until the strap is taken the map follows the filtered strap
wire       seven_now = strap_taken ? variant_seven : filt[64];
wire [7:0] next_group_status = group_fault(chan_fault, seven_now);

// chain fill count: reset values must not pass for a strap
always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		fill <= 3'h0;
	end else if (ce) begin
		if (fill != `STRAP_SETTLE) begin
			fill <= fill + 3'h1;
		end
	end
end

// strap sampled once: a moving strap would reshape the map
always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		strap_taken <= 1'b0;
		variant_seven <= 1'b0;
	end else if (ce) begin
		if (!strap_taken && fill == `STRAP_SETTLE) begin
			strap_taken <= 1'b1;
			variant_seven <= filt[64];
		end
	end
end

// live flags, not sticky: a cleared fault clears its group
always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		group_status <= `FAULT_STATUS_RESET;
	end else if (ce) begin
		group_status <= next_group_status;
	end
end

// holding register port
function reg_hit;
	input [15:0] addr;
	begin
		reg_hit = (addr == `FAULT_STATUS_OFFSET);
	end
endfunction

reg  [15:0] next_reg_rdata;
reg         next_reg_ack;
reg         next_reg_err;

// every strobe is answered next cycle, no wait states
always @* begin
	next_reg_ack = reg_rd | reg_wr;
	// write has no effect: register is read only
	next_reg_err = reg_wr | (reg_rd & ~reg_hit(reg_addr));
	next_reg_rdata = 16'h0000;
	if (reg_rd && reg_hit(reg_addr)) begin
		next_reg_rdata = {8'h00, group_status};
	end
end

always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		reg_ack <= 1'b0;
		reg_err <= 1'b0;
	end else if (ce) begin
		reg_ack <= next_reg_ack;
		reg_err <= next_reg_err;
	end
end

always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		reg_rdata <= 16'h0000;
	end else if (ce) begin
		reg_rdata <= next_reg_rdata;
	end
end

// ascii command parser and reply sender
reg  [2:0] state;
reg  [2:0] next_state;
reg  [3:0] tx_idx;
reg  [7:0] snap;
wire [3:0] ngroups = variant_seven ? `GROUPS_SEVEN : `GROUPS_FULL;
wire [3:0] last_idx = `REPLY_PREFIX_LEN + ngroups;
wire       rx_take = rx_valid & rx_ready;

assign rx_ready = (state != ST_TX);

always @* begin
	next_state = state;
	if (rx_take) begin
		// a stray '$' always restarts a command
		next_state = (rx_data == `CHAR_DOLLAR) ? ST_ADDR0 : ST_IDLE;
		case (state)
			ST_ADDR0: begin
				if (rx_data == `CHAR_ZERO)
					next_state = ST_ADDR1;
			end
			ST_ADDR1: begin
				if (rx_data == `CHAR_ONE)
					next_state = ST_CMD;
			end
			ST_CMD: begin
				if (rx_data == `CHAR_SEVEN)
					next_state = ST_END;
			end
			ST_END: begin
				if (rx_data == `CHAR_CR)
					next_state = ST_TX;
			end
			default: begin
			end
		endcase
	end
end

reg  [2:0] next_fsm;
reg  [3:0] next_tx_idx;
reg        next_tx_valid;
reg  [7:0] next_tx_data;
reg  [7:0] next_snap;

// reply moves only on a taken byte, so the sink may stall freely
always @* begin
	next_fsm = state;
	next_tx_idx = tx_idx;
	next_tx_valid = tx_valid;
	next_tx_data = tx_data;
	next_snap = snap;
	case (state)
		ST_TX: begin
			if (tx_valid && tx_ready) begin
				if (tx_idx == last_idx) begin
					next_tx_valid = 1'b0;
					next_fsm = ST_IDLE;
				end else begin
					next_tx_idx = tx_idx + 4'h1;
					next_tx_data = reply_char(tx_idx + 4'h1, ngroups, snap);
				end
			end
		end
		default: begin
			next_fsm = next_state;
			if (next_state == ST_TX) begin
				// snapshot keeps one reply self consistent
				next_snap = group_status;
				next_tx_idx = 4'h0;
				next_tx_valid = 1'b1;
				next_tx_data = `CHAR_BANG;
			end
		end
	endcase
end

always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		state <= ST_IDLE;
		tx_idx <= 4'h0;
		snap <= 8'h00;
		tx_valid <= 1'b0;
		tx_data <= 8'h00;
	end else if (ce) begin
		state <= next_fsm;
		tx_idx <= next_tx_idx;
		snap <= next_snap;
		tx_valid <= next_tx_valid;
		tx_data <= next_tx_data;
	end
end

endmodule // output_fault_status_reporter

// *** test/host_model.sv ***
// host sending the status command and sinking the reply
`timescale 1ns/100ps
module host_model (
	input  wire        clk_sys,
	input  wire        go,
	input  wire        rx_ready,
	input  wire        tx_valid,
	input  wire [7:0]  tx_data,
	output wire        rx_valid,
	output wire [7:0]  rx_data,
	output reg         tx_ready = 0,
	output reg  [95:0] got = 0,
	output reg  [3:0]  n = 0
);
	reg  [2:0]  k = 0;
	wire [39:0] c = 40'h243031370D;
	assign rx_valid = k != 0;
	// idle line shows the inverse of the last byte
	assign rx_data = k ? c[8*k-1 -: 8] : 8'hF2;
	always @(posedge clk_sys) begin
		tx_ready <= ~tx_ready; // stalls every other cycle
		if (tx_valid && tx_ready) begin
			got <= {got[87:0], tx_data};
			n <= n + 1;
		end
		if (go) begin
			k <= 5;
			got <= 0;
			n <= 0;
		end else if (rx_valid && rx_ready)
			k <= k - 1;
	end
endmodule // host_model

// *** test/ofsr_chk.sv ***
// port checker for the fault status reporter
`timescale 1ns/100ps
module ofsr_chk (
	input wire        clk_sys,
	input wire        reset_n,
	input wire        reg_rd,
	input wire        reg_wr,
	input wire [15:0] reg_addr,
	input wire [15:0] reg_rdata,
	input wire        reg_ack,
	input wire        reg_err,
	input wire        rx_ready,
	input wire        tx_valid,
	input wire [7:0]  tx_data,
	input wire        tx_ready,
	input wire [7:0]  group_status,
	input wire        variant_seven
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	property p_ack; reg_rd || reg_wr |=> reg_ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_wr; reg_wr |=> reg_err; endproperty
	a_wr: assert property (p_wr) else $error("write taken");
	property p_rd; reg_rd && reg_addr == 16'h9D73 |=> reg_rdata == {8'h00, $past(group_status)} && !reg_err; endproperty
	a_rd: assert property (p_rd) else $error("bad read");
	property p_unm; reg_rd && reg_addr != 16'h9D73 |=> reg_rdata == 16'h0000 && reg_err; endproperty
	a_unm: assert property (p_unm) else $error("bad unmapped");
	property p_sev; variant_seven |-> group_status[7:4] == 4'h0; endproperty
	a_sev: assert property (p_sev) else $error("upper groups");
	property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
	a_hold: assert property (p_hold) else $error("tx dropped");
	property p_busy; tx_valid |-> !rx_ready; endproperty
	a_busy: assert property (p_busy) else $error("rx open");
	property p_first; $rose(tx_valid) |-> tx_data == 8'h21; endproperty
	a_first: assert property (p_first) else $error("bad prefix");
	c_err: cover property (reg_err);
	c_tx: cover property ($rose(tx_valid));
	c_sev: cover property (variant_seven);
endmodule // ofsr_chk

// *** test/output_fault_status_reporter_bench.sv ***
// bench for the fault status reporter
`timescale 1ns/100ps
module output_fault_status_reporter_bench;
	reg         clk_sys = 0, reset_n = 0, ce = 1, seven_channel = 0, reg_rd = 0, reg_wr = 0, go = 0;
	reg  [15:0] out_active = 0, open_load = 0, short_gnd = 0, over_current = 0, reg_addr = 0, reg_wdata = 16'h00FF, ch;
	wire [15:0] reg_rdata;
	wire        reg_ack, reg_err, rx_ready, tx_valid, rx_valid, tx_ready, variant_seven;
	wire [7:0]  tx_data, rx_data, group_status;
	wire [95:0] got;
	wire [3:0]  n;
	reg  [95:0] e;
	integer     miscompares = 0, check_count = 0, i, k;
	output_fault_status_reporter dut (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .out_active(out_active),
		.open_load(open_load), .short_gnd(short_gnd), .over_current(over_current), .seven_channel(seven_channel),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_ack(reg_ack), .reg_err(reg_err), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .group_status(group_status),
		.variant_seven(variant_seven));
	host_model host (.clk_sys(clk_sys), .go(go), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready), .got(got), .n(n));
	initial forever #12.5 clk_sys = ~clk_sys;
	task chk(input [95:0] a, input [95:0] b); begin
		check_count = check_count + 1;
		if (a !== b) begin
			miscompares = miscompares + 1;
			$display("[FAIL] %0t got %h want %h", $time, a, b);
		end
	end endtask
	task final_report; begin
		if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	end endtask
	task acc(input w, input [15:0] a, input [15:0] d, input x); begin
		@(posedge clk_sys) {reg_rd, reg_wr, reg_addr} <= {!w, w, a};
		@(posedge clk_sys) {reg_rd, reg_wr} <= 2'b00;
		#1 chk({reg_ack, reg_err, reg_rdata}, {1'b1, x, d});
	end endtask
	task cmd(input [3:0] ng, input [7:0] s); begin
		e = 96'h213031;
		for (k = ng - 1; k >= 0; k = k - 1) e = {e[87:0], s[k] ? 8'h31 : 8'h30};
		e = {e[87:0], 8'h0D};
		@(posedge clk_sys) go <= 1;
		@(posedge clk_sys) go <= 0;
		for (k = 0; k < 200 && n !== ng + 4; k = k + 1) @(posedge clk_sys);
		if (k == 200) chk(0, 1);
		if (k == 200) final_report;
		chk(got, e);
	end endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		reset_n <= 1;
		for (i = 0; i < 64; i = i + 1) begin
			ch = 16'h0001 << (i / 4);
			k = i % 4;
			// last kind: open load on a driven channel is no fault
			@(posedge clk_sys) out_active <= k > 1 ? ch : 0;
			open_load <= k == 0 || k == 3 ? ch : 0;
			short_gnd <= k == 1 ? ch : 0;
			over_current <= k == 2 ? ch : 0;
			repeat (5) @(posedge clk_sys);
			acc(0, 16'h9D73, k < 3 ? 16'h0001 << (i / 8) : 0, 0);
		end
		@(posedge clk_sys) {out_active, over_current, open_load} <= {32'h0, 16'h0C0C};
		repeat (5) @(posedge clk_sys);
		acc(0, 16'h9D73, 16'h0022, 0);
		chk(variant_seven, 0);
		acc(1, 16'h9D73, 16'h0000, 1);
		acc(0, 16'h9D73, 16'h0022, 0);
		acc(0, 16'h9D74, 16'h0000, 1);
		cmd(8, 8'h22);
		@(posedge clk_sys) {ce, open_load} <= {1'b0, 16'h0000};
		repeat (6) @(posedge clk_sys);
		chk(group_status, 8'h22);
		@(posedge clk_sys) ce <= 1;
		repeat (6) @(posedge clk_sys);
		chk(group_status, 8'h00);
		@(posedge clk_sys) {reset_n, seven_channel, open_load} <= {2'b01, 16'hC040};
		repeat (5) @(posedge clk_sys);
		reset_n <= 1;
		repeat (8) @(posedge clk_sys);
		acc(0, 16'h9D73, 16'h0008, 0);
		chk(variant_seven, 1);
		cmd(4, 8'h08);
		final_report;
	end
endmodule // output_fault_status_reporter_bench
bind output_fault_status_reporter ofsr_chk chk_i (.clk_sys(clk_sys), .reset_n(reset_n), .reg_rd(reg_rd),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
	.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
	.group_status(group_status), .variant_seven(variant_seven));
